// >>> ihf_cfg.svh
`ifndef IHF_CFG_SVH
`define IHF_CFG_SVH
// ---------------------------------------------------------------
// Register indices (byte address = 4 * index, bit 8 = channel B)
// ---------------------------------------------------------------
`define IHF_IDX_ZCOEF_LO 8'h21
`define IHF_IDX_ZCOEF_HI 8'h34
`define IHF_IDX_KEY 8'h57
`define IHF_IDX_PWR 8'h7C
`define IHF_IDX_ANA 8'h0A
`define IHF_IDX_DIG 8'h0B
`define IHF_IDX_STAT 8'h0C
`define IHF_IDX_BAL_LO 8'h60
`define IHF_IDX_BAL_HI 8'h69
`define IHF_CHAN_BIT 8
// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define IHF_ANA_EN_BIT 7
`define IHF_HYB_DIS_BIT 4
`define IHF_PWR_FORCE_BIT 6
`define IHF_STAT_UNL_BIT 0
`define IHF_STAT_CLK_BIT 1
`define IHF_PWR_RST 8'h00
`define IHF_ANA_RST 8'h00
`define IHF_DIG_RST 8'h00
`define IHF_COEF_RST 8'h00
// ---------------------------------------------------------------
// Protection key sequence
// ---------------------------------------------------------------
`define IHF_KEY0 8'h02
`define IHF_KEY1 8'h06
`define IHF_KEY2 8'h0C
`define IHF_KEY3 8'h00
// ---------------------------------------------------------------
// Filter shapes
// ---------------------------------------------------------------
`define IHF_CW 8
`define IHF_SW 16
`define IHF_ZCOEFS 20
`define IHF_ZTAPS 18
`define IHF_BCOEFS 10
`define IHF_BTAPS 8
`define IHF_COEF_FRAC 7
`define IHF_FIFO_DEPTH 16
`define IHF_NCH 2
`endif

// >>> ihf_ctrl.sv
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "ihf_cfg.svh"
// Notes on behaviour
// - Twenty impedance coefficient bytes per line drive a digital filter.
// - Analog impedance terms stay off while the analog enable bit is 0.
// - Filter clocks run only while needed and stop in dial breaks unless forced on.
// - A stopped impedance filter keeps its stored samples.
// - Force bit in the power register keeps filter and tx path running.
// - Key writes 02,06,0C,00 toggle the lock of the power register.
// - Balance uses an 8-tap FIR and a biquad feedback at sample rate.
// - The balance output is an echo estimate subtracted from tx.
// - Each line owns its own balance coefficient set.
// - The hybrid cancel disable bit removes the echo estimate.
module ihf_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] lineBreak,
  input wire logic smpInValid,
  output logic smpInReady,
  input wire logic smpInChan,
  input wire ihf_pkg::ihf_smp_t smpInRx,
  input wire ihf_pkg::ihf_smp_t smpInTx,
  output logic smpOutValid,
  input wire logic smpOutReady,
  output logic smpOutChan,
  output ihf_pkg::ihf_smp_t smpOutTx,
  output ihf_pkg::ihf_smp_t smpOutImp,
  output logic [1:0] highSpeedProcClock,
  output logic [1:0] analogImpOn
);
  import ihf_pkg::*;

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  ihf_byte_t zc_q [`IHF_NCH][`IHF_ZCOEFS];
  ihf_byte_t zc_d [`IHF_NCH][`IHF_ZCOEFS];
  ihf_byte_t bc_q [`IHF_NCH][`IHF_BCOEFS];
  ihf_byte_t bc_d [`IHF_NCH][`IHF_BCOEFS];
  ihf_byte_t ana_q [`IHF_NCH];
  ihf_byte_t ana_d [`IHF_NCH];
  ihf_byte_t dig_q [`IHF_NCH];
  ihf_byte_t dig_d [`IHF_NCH];
  ihf_byte_t pwr_q [`IHF_NCH];
  ihf_byte_t pwr_d [`IHF_NCH];
  ihf_key_t key_q [`IHF_NCH];
  ihf_key_t key_d [`IHF_NCH];
  logic [1:0] unl_q, unl_d;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic waitReq_q, waitReq_d;
  logic [31:0] rdata_q, rdata_d;
  logic busAcc, wrAcc;
  logic [8:0] idx;
  logic ch;
  ihf_byte_t reg8, wdat;

  function automatic logic inRange(input ihf_byte_t a,
                                   input ihf_byte_t lo,
                                   input ihf_byte_t hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic ihf_key_t keyRestart(input ihf_byte_t v);
    return (v == `IHF_KEY0) ? IHF_KEY_S1 : IHF_KEY_S0;
  endfunction

  assign idx = avs_address[10:2];
  assign ch = idx[`IHF_CHAN_BIT];
  assign reg8 = idx[7:0];
  assign wdat = avs_writedata[7:0];
  assign busAcc = (avs_read | avs_write) & ~waitReq_q;
  assign wrAcc = avs_write & busAcc & avs_byteenable[0];
  assign avs_waitrequest = waitReq_q;
  assign avs_readdata = rdata_q;

  // ---------------------------------------------------------------
  // Sample path signals
  // ---------------------------------------------------------------
  logic fOutValid, fOutReady;
  logic [2*`IHF_SW:0] fOutData;
  logic popCh;
  ihf_smp_t popRx, popTx;
  logic [1:0] run, stepCh;
  ihf_smp_t zY [`IHF_NCH];
  ihf_smp_t bY [`IHF_NCH];
  ihf_smp_t echo;
  logic outValid_q, outValid_d, outChan_q, outChan_d;
  ihf_smp_t outTx_q, outTx_d, outImp_q, outImp_d;
  logic [1:0] procClk_q, procClk_d, ana_on_q, ana_on_d;

  // ---------------------------------------------------------------
  // Register writes and key sequencer
  // ---------------------------------------------------------------
  always_comb begin
    zc_d = zc_q;
    bc_d = bc_q;
    ana_d = ana_q;
    dig_d = dig_q;
    pwr_d = pwr_q;
    key_d = key_q;
    unl_d = unl_q;
    if (wrAcc) begin
      if (inRange(reg8, `IHF_IDX_ZCOEF_LO, `IHF_IDX_ZCOEF_HI)) begin
        zc_d[ch][5'(reg8 - `IHF_IDX_ZCOEF_LO)] = wdat;
      end else if (inRange(reg8, `IHF_IDX_BAL_LO, `IHF_IDX_BAL_HI)) begin
        bc_d[ch][4'(reg8 - `IHF_IDX_BAL_LO)] = wdat;
      end else if (reg8 == `IHF_IDX_ANA) begin
        ana_d[ch] = wdat;
      end else if (reg8 == `IHF_IDX_DIG) begin
        dig_d[ch] = wdat;
      end else if (reg8 == `IHF_IDX_PWR) begin
        if (unl_q[ch]) begin
          pwr_d[ch] = wdat;
        end
      end else if (reg8 == `IHF_IDX_KEY) begin
        case (key_q[ch])
          IHF_KEY_S0: begin
            key_d[ch] = keyRestart(wdat);
          end
          IHF_KEY_S1: begin
            if (wdat == `IHF_KEY1) begin
              key_d[ch] = IHF_KEY_S2;
            end else begin
              key_d[ch] = keyRestart(wdat);
            end
          end
          IHF_KEY_S2: begin
            if (wdat == `IHF_KEY2) begin
              key_d[ch] = IHF_KEY_S3;
            end else begin
              key_d[ch] = keyRestart(wdat);
            end
          end
          default: begin
            if (wdat == `IHF_KEY3) begin
              key_d[ch] = IHF_KEY_S0;
              unl_d[ch] = ~unl_q[ch];
            end else begin
              key_d[ch] = keyRestart(wdat);
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int c = 0; c < `IHF_NCH; c++) begin
        for (int k = 0; k < `IHF_ZCOEFS; k++) begin
          zc_q[c][k] <= `IHF_COEF_RST;
        end
        for (int k = 0; k < `IHF_BCOEFS; k++) begin
          bc_q[c][k] <= `IHF_COEF_RST;
        end
        ana_q[c] <= `IHF_ANA_RST;
        dig_q[c] <= `IHF_DIG_RST;
        pwr_q[c] <= `IHF_PWR_RST;
        key_q[c] <= IHF_KEY_S0;
      end
      unl_q <= '0;
    end else begin
      zc_q <= zc_d;
      bc_q <= bc_d;
      ana_q <= ana_d;
      dig_q <= dig_d;
      pwr_q <= pwr_d;
      key_q <= key_d;
      unl_q <= unl_d;
    end
  end

  // ---------------------------------------------------------------
  // Wait state and read data
  // ---------------------------------------------------------------
  always_comb begin
    waitReq_d = ~((avs_read | avs_write) & waitReq_q);
    rdata_d = rdata_q;
    if (avs_read && waitReq_q) begin
      rdata_d = '0;
      if (inRange(reg8, `IHF_IDX_ZCOEF_LO, `IHF_IDX_ZCOEF_HI)) begin
        rdata_d = 32'(zc_q[ch][5'(reg8 - `IHF_IDX_ZCOEF_LO)]);
      end else if (inRange(reg8, `IHF_IDX_BAL_LO, `IHF_IDX_BAL_HI)) begin
        rdata_d = 32'(bc_q[ch][4'(reg8 - `IHF_IDX_BAL_LO)]);
      end else if (reg8 == `IHF_IDX_ANA) begin
        rdata_d = 32'(ana_q[ch]);
      end else if (reg8 == `IHF_IDX_DIG) begin
        rdata_d = 32'(dig_q[ch]);
      end else if (reg8 == `IHF_IDX_PWR) begin
        rdata_d = 32'(pwr_q[ch]);
      end else if (reg8 == `IHF_IDX_KEY) begin
        rdata_d = 32'(key_q[ch]);
      end else if (reg8 == `IHF_IDX_STAT) begin
        rdata_d[`IHF_STAT_UNL_BIT] = unl_q[ch];
        rdata_d[`IHF_STAT_CLK_BIT] = procClk_q[ch];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waitReq_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      waitReq_q <= waitReq_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Sample buffer
  // ---------------------------------------------------------------
  ihf_fifo #(
    .W(2*`IHF_SW+1),
    .DEPTH(`IHF_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .inValid(smpInValid),
    .inReady(smpInReady),
    .inData({smpInChan, smpInRx, smpInTx}),
    .outValid(fOutValid),
    .outReady(fOutReady),
    .outData(fOutData)
  );

  assign fOutReady = ~outValid_q | smpOutReady;
  assign popCh = fOutData[2*`IHF_SW];
  assign popRx = fOutData[2*`IHF_SW-1:`IHF_SW];
  assign popTx = fOutData[`IHF_SW-1:0];

  // ---------------------------------------------------------------
  // Per-line impedance and balance filters
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `IHF_NCH; g++) begin : g_line
      logic [`IHF_ZTAPS*`IHF_CW-1:0] zTap;
      logic [`IHF_BTAPS*`IHF_CW-1:0] bTap;
      always_comb begin
        for (int k = 0; k < `IHF_ZTAPS; k++) begin
          zTap[k*`IHF_CW +: `IHF_CW] = zc_q[g][k];
        end
        for (int k = 0; k < `IHF_BTAPS; k++) begin
          bTap[k*`IHF_CW +: `IHF_CW] = bc_q[g][k];
        end
      end
      // Clocks gate off in dial breaks unless forced on
      assign run[g] = pwr_q[g][`IHF_PWR_FORCE_BIT]
                      | ~lineBreak[g];
      assign stepCh[g] = fOutValid & fOutReady
                         & (popCh == 1'(g)) & run[g];
      ihf_filt #(
        .NTAP(`IHF_ZTAPS)
      ) u_imp (
        .clk(clk),
        .reset_n(reset_n),
        .step(stepCh[g]),
        .x(popTx),
        .coef(zTap),
        .fb({zc_q[g][`IHF_ZTAPS+1], zc_q[g][`IHF_ZTAPS]}),
        .y(zY[g])
      );
      ihf_filt #(
        .NTAP(`IHF_BTAPS)
      ) u_bal (
        .clk(clk),
        .reset_n(reset_n),
        .step(stepCh[g]),
        .x(popRx),
        .coef(bTap),
        .fb({bc_q[g][`IHF_BTAPS+1], bc_q[g][`IHF_BTAPS]}),
        .y(bY[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Echo cancel and output stage
  // ---------------------------------------------------------------
  always_comb begin
    echo = dig_q[popCh][`IHF_HYB_DIS_BIT] ? '0 : bY[popCh];
    outValid_d = outValid_q & ~smpOutReady;
    outChan_d = outChan_q;
    outTx_d = outTx_q;
    outImp_d = outImp_q;
    if (fOutValid && fOutReady) begin
      outValid_d = 1'b1;
      outChan_d = popCh;
      outTx_d = '0;
      outImp_d = '0;
      if (run[popCh]) begin
        outTx_d = ihf_sat(32'(popTx) - 32'(echo));
        outImp_d = zY[popCh];
      end
    end
    for (int c = 0; c < `IHF_NCH; c++) begin
      procClk_d[c] = run[c];
      ana_on_d[c] = ana_q[c][`IHF_ANA_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      outValid_q <= 1'b0;
      outChan_q <= 1'b0;
      outTx_q <= '0;
      outImp_q <= '0;
      procClk_q <= '0;
      ana_on_q <= '0;
    end else begin
      outValid_q <= outValid_d;
      outChan_q <= outChan_d;
      outTx_q <= outTx_d;
      outImp_q <= outImp_d;
      procClk_q <= procClk_d;
      ana_on_q <= ana_on_d;
    end
  end

  assign smpOutValid = outValid_q;
  assign smpOutChan = outChan_q;
  assign smpOutTx = outTx_q;
  assign smpOutImp = outImp_q;
  assign highSpeedProcClock = procClk_q;
  assign analogImpOn = ana_on_q;
endmodule

// >>> ihf_ctrl_monitor.sv
`timescale 1ns/10ps
module ihf_mon (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] lineBreak,
  input wire logic smpInValid,
  input wire logic smpInReady,
  input wire logic smpOutValid,
  input wire logic smpOutReady,
  input wire logic smpOutChan,
  input wire ihf_pkg::ihf_smp_t smpOutTx,
  input wire ihf_pkg::ihf_smp_t smpOutImp,
  input wire logic [1:0] highSpeedProcClock,
  input wire logic [1:0] analogImpOn
);
  import ihf_pkg::*;
  // ----------------------------------------
  // Bus and stream properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic req;
  assign req = avs_read | avs_write;
  property p_wait_ans;
    req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans)
    else $error("bus answer late");
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse)
    else $error("waitrequest low too long");
  property p_wait_cause;
    !avs_waitrequest |-> $past(req) && req;
  endproperty
  a_wait_cause: assert property (p_wait_cause)
    else $error("answer without request");
  property p_rd_hi;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi)
    else $error("read data upper bits set");
  property p_clk_run;
    $past(reset_n) |-> (highSpeedProcClock | $past(lineBreak)) == 2'h3;
  endproperty
  a_clk_run: assert property (p_clk_run)
    else $error("filter clock off outside dial break");
  property p_ana;
    avs_write && !avs_waitrequest && avs_byteenable[0] &&
      avs_address[10:2] == 9'h00A |->
      ##2 analogImpOn[0] == $past(avs_writedata[7], 2);
  endproperty
  a_ana: assert property (p_ana)
    else $error("analog enable does not follow register");
  property p_hold;
    smpOutValid && !smpOutReady |=> smpOutValid && $stable(smpOutTx)
      && $stable(smpOutImp) && $stable(smpOutChan);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output word changed while stalled");
  property p_lat;
    smpInValid && smpInReady && !smpOutValid |-> ##[1:2] smpOutValid;
  endproperty
  a_lat: assert property (p_lat)
    else $error("sample not forwarded in time");
  c_pwr: cover property (avs_write && !avs_waitrequest &&
    avs_address[9:2] == 8'h7C);
  c_stall: cover property (smpOutValid && !smpOutReady);
  c_full: cover property (smpInValid && !smpInReady);
endmodule
bind ihf_ctrl ihf_mon u_mon (.clk(clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .lineBreak(lineBreak), .smpInValid(smpInValid), .smpInReady(smpInReady),
  .smpOutValid(smpOutValid), .smpOutReady(smpOutReady),
  .smpOutChan(smpOutChan), .smpOutTx(smpOutTx), .smpOutImp(smpOutImp),
  .highSpeedProcClock(highSpeedProcClock), .analogImpOn(analogImpOn));

// >>> ihf_ctrl_tb_top.sv
`timescale 1ns/10ps
module ihf_ctrl_tb_top;
  import ihf_pkg::*;
  logic clk = 0;
  logic reset_n = 0;
  logic [10:0] avs_address = 0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 0;
  logic [31:0] avs_readdata;
  logic [3:0] avs_byteenable = 4'h1;
  logic avs_waitrequest, smpInReady, smpOutValid, smpOutReady, smpOutChan;
  logic [1:0] lineBreak = 2'h0;
  logic [1:0] highSpeedProcClock, analogImpOn;
  logic smpInValid = 0, smpInChan = 0, stall = 0, hold = 0, hyb = 0;
  logic forced = 0, zimp = 0;
  ihf_smp_t smpInRx = 0, smpInTx = 0, smpOutTx, smpOutImp, lastA = 0;
  int failures = 0, n_compared = 0, seed = 32'h125A, i;
  logic [32:0] expQ[$];
  logic [7:0] q;
  logic [7:0] keys [4] = '{8'h02, 8'h06, 8'h0C, 8'h00};
  logic [8:0] rst [7] = '{9'h057, 9'h07C, 9'h00A, 9'h00B, 9'h021, 9'h069,
    9'h001};
  always #4 clk = ~clk;
  always @(posedge clk) stall <= hold | (($random(seed) & 3) == 0);
  ihf_ctrl dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .lineBreak(lineBreak), .smpInValid(smpInValid), .smpInReady(smpInReady),
    .smpInChan(smpInChan), .smpInRx(smpInRx), .smpInTx(smpInTx),
    .smpOutValid(smpOutValid), .smpOutReady(smpOutReady),
    .smpOutChan(smpOutChan), .smpOutTx(smpOutTx), .smpOutImp(smpOutImp),
    .highSpeedProcClock(highSpeedProcClock), .analogImpOn(analogImpOn));
  ihf_sink sink (.clk(clk), .reset_n(reset_n), .stall(stall),
    .smpOutValid(smpOutValid), .smpOutChan(smpOutChan),
    .smpOutTx(smpOutTx), .smpOutImp(smpOutImp), .smpOutReady(smpOutReady));
  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  task automatic report_and_stop;
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic timeout;
    failures++;
    report_and_stop();
  endtask
  task automatic chk(input string nm, input logic [32:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic rdn, input logic [8:0] idx,
    input logic [7:0] d);
    int k;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_read <= rdn;
    avs_write <= !rdn;
    avs_writedata <= {24'h0, d};
    for (k = 0; k < 64; k++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k == 64) timeout();
  endtask
  task automatic rdchk(input logic [8:0] idx, input logic [7:0] e);
    bus(1'b1, idx, 8'h00);
    chk("reg", q, e);
  endtask
  task automatic keyseq;
    int c, j;
    for (c = 0; c < 2; c++) begin
      for (j = 0; j < 4; j++) bus(1'b0, {c[0], 8'h57}, keys[j]);
    end
  endtask
  function automatic logic [32:0] expw(input logic c, input ihf_smp_t tx,
    input ihf_smp_t rx);
    logic signed [17:0] t, s;
    if (lineBreak[c] && !forced) return {c, 32'h0};
    t = tx - ((!c && !hyb) ? (rx >>> 1) : 18'sh0);
    s = (zimp && !c) ? ((tx + lastA) >>> 1) : 18'sh0;
    if (!c) lastA = tx;
    if (t > 18'sh07FFF) t = 18'sh07FFF;
    else if (t < -18'sh08000) t = -18'sh08000;
    return {c, t[15:0], s[15:0]};
  endfunction
  task automatic burst(input int n);
    int j, k;
    logic c;
    ihf_smp_t tx, rx;
    @(posedge clk);
    for (j = 0; j < n; j++) begin
      c = (j == 0) ? 1'b0 : 1'($random(seed));
      tx = (j == 0) ? 16'h8000 : 16'($random(seed));
      rx = (j == 0) ? 16'h7FFF : 16'($random(seed));
      smpInValid <= 1'b1;
      smpInChan <= c;
      smpInTx <= tx;
      smpInRx <= rx;
      for (k = 0; k < 64; k++) begin
        @(posedge clk);
        if (smpInReady === 1'b1) break;
      end
      if (k == 64) timeout();
      expQ.push_back(expw(c, tx, rx));
    end
    smpInValid <= 1'b0;
  endtask
  task automatic drain;
    int k;
    for (k = 0; k < 900 && sink.got.size() < expQ.size(); k++)
      @(posedge clk);
    if (sink.got.size() < expQ.size()) timeout();
    while (expQ.size() > 0)
      chk("word", sink.got.pop_front(), expQ.pop_front());
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    lineBreak <= 2'b10;
    for (i = 0; i < 7; i++) rdchk(rst[i], 8'h00);
    bus(1'b0, 9'h001, 8'hFF);
    rdchk(9'h001, 8'h00);
    avs_byteenable <= 4'h0;
    bus(1'b0, 9'h00B, 8'h10);
    avs_byteenable <= 4'h1;
    rdchk(9'h00B, 8'h00);
    bus(1'b0, 9'h00A, 8'h80);
    repeat (2) @(posedge clk);
    chk("analog", analogImpOn, 2'b01);
    bus(1'b0, 9'h00A, 8'h00);
    repeat (2) @(posedge clk);
    chk("analog", analogImpOn, 2'b00);
    for (i = 0; i < 10; i++) begin
      bus(1'b0, 9'h060 + i, (i == 0) ? 8'h40 : 8'h00);
      bus(1'b0, 9'h160 + i, 8'h00);
    end
    bus(1'b0, 9'h021, 8'h40);
    bus(1'b0, 9'h022, 8'h40);
    zimp = 1'b1;
    chk("clock", highSpeedProcClock, 2'b01);
    hold <= 1'b1;
    burst(17);
    repeat (2) @(posedge clk);
    chk("full", smpInReady, 1'b0);
    hold <= 1'b0;
    drain();
    burst(40);
    drain();
    lineBreak <= 2'b00;
    hyb = 1'b1;
    bus(1'b0, 9'h00B, 8'h10);
    burst(20);
    drain();
    lineBreak <= 2'b01;
    burst(8);
    drain();
    lineBreak <= 2'b00;
    burst(8);
    drain();
    lineBreak <= 2'b11;
    bus(1'b0, 9'h057, 8'h02);
    rdchk(9'h057, 8'h01);
    bus(1'b0, 9'h057, 8'h06);
    bus(1'b0, 9'h057, 8'h05);
    rdchk(9'h057, 8'h00);
    bus(1'b0, 9'h07C, 8'hC0);
    rdchk(9'h07C, 8'h00);
    keyseq();
    rdchk(9'h00C, 8'h01);
    bus(1'b0, 9'h07C, 8'h80);
    bus(1'b0, 9'h17C, 8'h80);
    rdchk(9'h17C, 8'h80);
    chk("clock", highSpeedProcClock, 2'b00);
    for (i = 8'h21; i <= 8'h34; i++) begin
      bus(1'b0, i[8:0], 8'h00);
      bus(1'b0, 9'h100 + i, 8'h00);
    end
    zimp = 1'b0;
    bus(1'b0, 9'h07C, 8'hC0);
    bus(1'b0, 9'h17C, 8'hC0);
    forced = 1'b1;
    repeat (2) @(posedge clk);
    chk("clock", highSpeedProcClock, 2'b11);
    keyseq();
    rdchk(9'h00C, 8'h02);
    bus(1'b0, 9'h07C, 8'h00);
    rdchk(9'h07C, 8'hC0);
    burst(20);
    drain();
    report_and_stop();
  end
endmodule

// >>> ihf_fifo.sv
`timescale 1ns/10ps
module ihf_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic nf_q, nf_d, ne_q, ne_d;
  logic push, pop;

  assign push = inValid & nf_q;
  assign pop = ne_q & outReady;
  assign inReady = nf_q;
  assign outValid = ne_q;
  assign outData = mem[rp_q];

  // ---------------------------------------------------------------
  // Pointers and fill level
  // ---------------------------------------------------------------
  always_comb begin
    wp_d = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d = pop ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = CW'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = CW'(cnt_q - 1'b1);
    end
    nf_d = cnt_d != CW'(DEPTH);
    ne_d = cnt_d != '0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      nf_q <= 1'b1;
      ne_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      nf_q <= nf_d;
      ne_q <= ne_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= inData;
    end
  end
endmodule

// >>> ihf_filt.sv
`timescale 1ns/10ps
`include "ihf_cfg.svh"
module ihf_filt #(
  parameter int NTAP = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic step,
  input wire ihf_pkg::ihf_smp_t x,
  input wire logic [NTAP*`IHF_CW-1:0] coef,
  input wire logic [2*`IHF_CW-1:0] fb,
  output ihf_pkg::ihf_smp_t y
);
  import ihf_pkg::*;
  ihf_smp_t hist_q [NTAP];
  ihf_smp_t hist_d [NTAP];
  ihf_smp_t y1_q, y1_d, y2_q, y2_d;
  logic signed [31:0] acc;

  // ---------------------------------------------------------------
  // FIR taps plus second-order feedback
  // ---------------------------------------------------------------
  always_comb begin
    acc = $signed(coef[0 +: `IHF_CW]) * x;
    // Tap k weighs the sample stored k steps back
    for (int k = 1; k < NTAP; k++) begin
      acc = acc + $signed(coef[k*`IHF_CW +: `IHF_CW]) * hist_q[k-1];
    end
    acc = acc + $signed(fb[0 +: `IHF_CW]) * y1_q;
    acc = acc + $signed(fb[`IHF_CW +: `IHF_CW]) * y2_q;
    y = ihf_sat(acc >>> `IHF_COEF_FRAC);
  end

  // History only moves on a step; otherwise it holds its samples
  always_comb begin
    hist_d = hist_q;
    y1_d = y1_q;
    y2_d = y2_q;
    if (step) begin
      hist_d[0] = x;
      for (int k = 1; k < NTAP; k++) begin
        hist_d[k] = hist_q[k-1];
      end
      y1_d = y;
      y2_d = y1_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < NTAP; k++) begin
        hist_q[k] <= '0;
      end
      y1_q <= '0;
      y2_q <= '0;
    end else begin
      hist_q <= hist_d;
      y1_q <= y1_d;
      y2_q <= y2_d;
    end
  end
endmodule

// >>> ihf_pkg.sv
package ihf_pkg;
  typedef enum logic [1:0] {
    IHF_KEY_S0 = 2'b00,
    IHF_KEY_S1 = 2'b01,
    IHF_KEY_S2 = 2'b10,
    IHF_KEY_S3 = 2'b11
  } ihf_key_t;
  typedef logic signed [15:0] ihf_smp_t;
  typedef logic [7:0] ihf_byte_t;

  function automatic ihf_smp_t ihf_sat(input logic signed [31:0] v);
    if (v > 32'sh00007FFF) begin
      return 16'sh7FFF;
    end else if (v < -32'sh00008000) begin
      return -16'sh8000;
    end
    return ihf_smp_t'(v);
  endfunction
endpackage

// >>> ihf_sink.sv
`timescale 1ns/10ps
module ihf_sink (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic stall,
  input wire logic smpOutValid,
  input wire logic smpOutChan,
  input wire ihf_pkg::ihf_smp_t smpOutTx,
  input wire ihf_pkg::ihf_smp_t smpOutImp,
  output logic smpOutReady
);
  import ihf_pkg::*;
  // ----------------------------------------
  // Sample sink, stalls when told
  // ----------------------------------------
  logic [32:0] got[$];
  assign smpOutReady = !stall;
  always @(posedge clk) begin
    if (reset_n && smpOutValid && smpOutReady) begin
      got.push_back({smpOutChan, smpOutTx, smpOutImp});
    end
  end
endmodule
